// File: rtl/cofp_top.sv
// Current offset trim and output OV fault policy registers.
// Assumes a command-level port fed by the bus front end on SYS_CLK,
// an OV detector on the same clock, and a loop-slave strap pin.
`timescale 1ns/1ps
module cofp_top
  import cofp_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic CMD_VALID,
  input wire logic CMD_WRITE,
  input wire logic [7:0] CMD_CODE,
  input wire logic [15:0] CMD_WDATA,
  input wire logic LOOP_SLAVE,
  input wire logic OV_DETECT,
  input wire logic ALERT_MASK_OV,
  input wire logic OUTPUT_ON,
  input wire logic OTHER_FAULT,
  input wire logic [RISE_W-1:0] RISE_CYCLES,
  input wire logic [15:0] IOUT_RAW,
  input wire logic [15:0] OC_FAULT_RAW,
  input wire logic [15:0] OC_WARN_RAW,
  output logic RSP_VALID,
  output logic RSP_NACK,
  output logic [15:0] RSP_RDATA,
  output logic [15:0] IOUT_ADJ,
  output logic [15:0] OC_FAULT_ADJ,
  output logic [15:0] OC_WARN_ADJ,
  output logic STAT_VOUT_OV,
  output logic STAT_CML_IVC,
  output logic STAT_CML_IVD,
  output logic SMBALERT_O,
  output logic SMBALERT_OE,
  output logic NV_STORE,
  output logic [TRIM_LOW_W:0] NV_TRIM_BITS,
  output logic [1:0] NV_OV_BITS,
  output logic POWER_EN,
  output logic RETRY_PENDING
);

  // ----------------------------------------------------------------
  // State and sequencer
  // ----------------------------------------------------------------
  cofp_reg_t r;
  cofp_reg_t next_r;
  cofp_seq_if sq ();

  cofp_seq u_seq (
    .clk(SYS_CLK),
    .reset_n(RESET_N),
    .sq(sq.seq)
  );

  // Policy and run inputs toward the sequencer
  assign sq.act_enable = r.ov_act;
  assign sq.restart_on = r.ov_rs;
  assign sq.ov_event = r.ov_event;
  assign sq.on_cmd = OUTPUT_ON;
  assign sq.other_fault = OTHER_FAULT;
  assign sq.clear = r.clear;
  assign sq.rise_cycles = RISE_CYCLES;

  // ----------------------------------------------------------------
  // Next value
  // ----------------------------------------------------------------
  logic wr;
  logic rd;
  logic [15:0] trim_word;
  logic [7:0] ov_byte;
  logic [7:0] st_byte;
  logic [15:0] st_word;
  logic [7:0] st_vout;
  logic [7:0] st_cml;
  logic [15:0] trim_ext;
  logic [2:0] rs_field;
  logic set_ivc;
  logic set_ivd;
  logic set_ov;

  always_comb begin
    next_r = r;
    wr = CMD_VALID & CMD_WRITE;
    rd = CMD_VALID & ~CMD_WRITE;
    set_ivc = 1'b0;
    set_ivd = 1'b0;
    rs_field = CMD_WDATA[OV_RS_HI:OV_RS_LO];

    // Strap sampled through two flops, caught once it settles
    next_r.strap_s1 = LOOP_SLAVE;
    next_r.strap_s2 = r.strap_s1;
    if (r.strap_cnt != STRAP_SETTLE) begin
      next_r.strap_cnt = r.strap_cnt + 2'h1;
      next_r.loop_slave = r.strap_s2;
    end

    // Register images as read back
    trim_word = {TRIM_EXP, r.trim_sign, {TRIM_EXT_W{r.trim_sign}},
                 r.trim_low};
    ov_byte = 8'h00;
    ov_byte[OV_ACT_BIT] = r.ov_act;
    ov_byte[OV_RS_HI:0] = {(OV_RS_HI + 1){r.ov_rs}};

    // Status images
    st_vout = 8'h00;
    st_vout[SV_OV_BIT] = r.f_vout_ov;
    st_cml = 8'h00;
    st_cml[SC_IVC_BIT] = r.f_ivc;
    st_cml[SC_IVD_BIT] = r.f_ivd;
    st_byte = 8'h00;
    st_byte[SB_VOUT_OV_BIT] = r.f_vout_ov;
    st_byte[SB_CML_BIT] = r.f_ivc | r.f_ivd;
    st_word = {8'h00, st_byte};
    st_word[SW_VOUT_BIT] = r.f_vout_ov;

    // Command response defaults
    next_r.rsp_valid = CMD_VALID;
    next_r.rsp_nack = 1'b0;
    next_r.rsp_rdata = 16'h0000;
    next_r.nv_store = 1'b0;
    next_r.clear = 1'b0;

    // ----------------------------------------------------------------
    // Command decode
    // ----------------------------------------------------------------
    if (CMD_VALID) begin
      case (CMD_CODE)
        // Trim: only the sign and the six low bits take a write
        CMD_TRIM: begin
          if (wr) begin
            next_r.trim_sign = CMD_WDATA[TRIM_SIGN_BIT];
            next_r.trim_low = CMD_WDATA[TRIM_LOW_W-1:0];
          end else begin
            next_r.rsp_rdata = trim_word;
          end
        end

        // Policy: refused on a loop slave, restart codes other than 000 and 111 rejected
        CMD_OV_ACTION: begin
          if (r.loop_slave) begin
            next_r.rsp_nack = 1'b1;
            set_ivc = 1'b1;
          end else if (rd) begin
            next_r.rsp_rdata = {8'h00, ov_byte};
          end else if (rs_field == 3'h0 || rs_field == 3'h7) begin
            next_r.ov_act = CMD_WDATA[OV_ACT_BIT];
            next_r.ov_rs = CMD_WDATA[OV_RS_HI];
          end else begin
            set_ivd = 1'b1;
          end
        end

        // Clear faults: write only, a read is refused
        CMD_CLEAR_FAULTS: begin
          next_r.clear = wr;
          if (rd) begin
            next_r.rsp_nack = 1'b1;
            set_ivc = 1'b1;
          end
        end

        // Store all: snapshot now, pulse toward storage next cycle
        CMD_STORE_ALL: begin
          next_r.nv_store = wr;
          next_r.nv_trim = {r.trim_sign, r.trim_low};
          next_r.nv_ov = {r.ov_act, r.ov_rs};
          if (rd) begin
            next_r.rsp_nack = 1'b1;
            set_ivc = 1'b1;
          end
        end

        // Status images: reads return them, writes are only acknowledged
        CMD_STATUS_BYTE: begin
          if (rd) begin
            next_r.rsp_rdata = {8'h00, st_byte};
          end
        end
        CMD_STATUS_WORD: begin
          if (rd) begin
            next_r.rsp_rdata = st_word;
          end
        end
        CMD_STATUS_VOUT: begin
          if (rd) begin
            next_r.rsp_rdata = {8'h00, st_vout};
          end
        end
        CMD_STATUS_CML: begin
          if (rd) begin
            next_r.rsp_rdata = {8'h00, st_cml};
          end
        end

        // Anything else is an invalid command
        default: begin
          next_r.rsp_nack = 1'b1;
          set_ivc = 1'b1;
        end
      endcase
    end

    // OV event from detector rising edge
    next_r.ov_d = OV_DETECT;
    set_ov = OV_DETECT & ~r.ov_d;
    next_r.ov_event = set_ov;

    // ----------------------------------------------------------------
    // Fault flags and alert
    // ----------------------------------------------------------------
    // Sticky flags: clear first, a same-cycle set wins
    if (r.clear) begin
      next_r.f_vout_ov = 1'b0;
      next_r.f_ivc = 1'b0;
      next_r.f_ivd = 1'b0;
    end
    if (set_ov) begin
      next_r.f_vout_ov = 1'b1;
    end
    if (set_ivc) begin
      next_r.f_ivc = 1'b1;
    end
    if (set_ivd) begin
      next_r.f_ivd = 1'b1;
    end

    // Alert follows unmasked flags
    next_r.alert = (next_r.f_vout_ov & ~ALERT_MASK_OV) |
                   next_r.f_ivc | next_r.f_ivd;

    // ----------------------------------------------------------------
    // Telemetry trim
    // ----------------------------------------------------------------
    // Offset applied to telemetry and limits
    trim_ext = {{(16 - TRIM_LOW_W){r.trim_sign}}, r.trim_low};
    next_r.iout_adj = IOUT_RAW + trim_ext;
    next_r.ocf_adj = OC_FAULT_RAW - trim_ext;
    next_r.ocw_adj = OC_WARN_RAW - trim_ext;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      r <= '0;
      r.strap_cnt <= 2'h0;
      r.trim_sign <= TRIM_RESET[TRIM_SIGN_BIT];
      r.trim_low <= TRIM_RESET[TRIM_LOW_W-1:0];
      r.ov_act <= OV_RESET[OV_ACT_BIT];
      r.ov_rs <= OV_RESET[OV_RS_HI];
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign RSP_VALID = r.rsp_valid;
  assign RSP_NACK = r.rsp_nack;
  assign RSP_RDATA = r.rsp_rdata;
  assign IOUT_ADJ = r.iout_adj;
  assign OC_FAULT_ADJ = r.ocf_adj;
  assign OC_WARN_ADJ = r.ocw_adj;
  assign STAT_VOUT_OV = r.f_vout_ov;
  assign STAT_CML_IVC = r.f_ivc;
  assign STAT_CML_IVD = r.f_ivd;
  assign SMBALERT_O = 1'b0; // Open drain, only ever pulls low
  assign SMBALERT_OE = r.alert;
  assign NV_STORE = r.nv_store;
  assign NV_TRIM_BITS = r.nv_trim;
  assign NV_OV_BITS = r.nv_ov;
  assign POWER_EN = sq.power_en;
  assign RETRY_PENDING = sq.retrying;

endmodule : cofp_top

// File: rtl/cofp_pkg.sv
// Constants and types for the current offset trim and OV fault policy.
// Assumes one clock domain and an already decoded command-level port.
//
// What this block does
// - Trim offset is added to current reading, subtracted from OC limits; resets 0 A.
// - Trim step is 62.5 mA, span +3.9375 A down to -4 A.
// - Out-of-span trim writes are accepted; written bits 9 to 6 are dropped and read back as sign copies.
// - Trim exponent reads -4; four mantissa bits below top copy the sign.
// - Trim exponent is fixed at 11100 and ignores writes.
// - Trim mantissa: writable sign, four extension bits, six writable low bits.
// - Store-all command saves both registers to nonvolatile storage.
// - OV fault sets byte, word and vout status flags and raises alert unless ALERT_MASK_OV is set.
// - Loop slave: OV action command ignored, NACKed, invalid command flagged.
// - Reset OV action: shut down, restart after seven rise times.
// - Act bit 0 keeps running and flags; 1 shuts down per mode.
// - Restart mode 000: stay off until faults are cleared, off or other fault.
// - Restart mode 111: retry soft start until off or other fault.
// - Restart mode other than 000/111 rejected, CML and invalid data flagged.
// - Only bit 5 of the restart mode is kept in storage.
// - Delay field 000: no delay, only with mode 000, stays off.
// - Delay field 111: wait seven rise times, only with mode 111.
// - Delay field is read-only and mirrors stored bit 5.
package cofp_pkg;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_STORE_ALL = 8'h11;
  localparam logic [7:0] CMD_TRIM = 8'h39;
  localparam logic [7:0] CMD_OV_ACTION = 8'h41;
  localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
  localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
  localparam logic [7:0] CMD_STATUS_VOUT = 8'h7a;
  localparam logic [7:0] CMD_STATUS_CML = 8'h7e;

  // ----------------------------------------------------------------
  // Field layouts and reset values
  // ----------------------------------------------------------------
  localparam logic [4:0] TRIM_EXP = 5'h1c;
  localparam int TRIM_SIGN_BIT = 10;
  localparam int TRIM_EXT_W = 4;
  localparam int TRIM_LOW_W = 6;
  localparam logic [15:0] TRIM_RESET = 16'he000;
  localparam int OV_ACT_BIT = 7;
  localparam int OV_RS_HI = 5;
  localparam int OV_RS_LO = 3;
  localparam logic [7:0] OV_RESET = 8'hbf;
  localparam int SB_VOUT_OV_BIT = 5;
  localparam int SB_CML_BIT = 1;
  localparam int SW_VOUT_BIT = 15;
  localparam int SV_OV_BIT = 7;
  localparam int SC_IVC_BIT = 7;
  localparam int SC_IVD_BIT = 6;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int RISE_W = 24;
  localparam logic [2:0] RETRY_RISE_COUNT = 3'h7;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b000,
    SEQ_RUN = 3'b001,
    SEQ_LATCH = 3'b010,
    SEQ_WAIT = 3'b011,
    SEQ_RAMP = 3'b100
  } cofp_seq_state_t;

  typedef struct packed {
    cofp_seq_state_t state;
    logic [RISE_W-1:0] cnt;
    logic [2:0] rep;
    logic power_en;
    logic retrying;
  } cofp_seq_reg_t;

  typedef struct packed {
    logic strap_s1;
    logic strap_s2;
    logic [1:0] strap_cnt;
    logic loop_slave;
    logic ov_d;
    logic trim_sign;
    logic [TRIM_LOW_W-1:0] trim_low;
    logic ov_act;
    logic ov_rs;
    logic f_vout_ov;
    logic f_ivc;
    logic f_ivd;
    logic clear;
    logic ov_event;
    logic rsp_valid;
    logic rsp_nack;
    logic [15:0] rsp_rdata;
    logic [15:0] iout_adj;
    logic [15:0] ocf_adj;
    logic [15:0] ocw_adj;
    logic alert;
    logic nv_store;
    logic [TRIM_LOW_W:0] nv_trim;
    logic [1:0] nv_ov;
  } cofp_reg_t;

endpackage : cofp_pkg

// File: rtl/cofp_seq_if.sv
// Link between the register side and the fault sequencer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface cofp_seq_if;
  import cofp_pkg::*;
  logic act_enable;
  logic restart_on;
  logic ov_event;
  logic on_cmd;
  logic other_fault;
  logic clear;
  logic [RISE_W-1:0] rise_cycles;
  logic power_en;
  logic retrying;

  modport regs (
    output act_enable, restart_on, ov_event, on_cmd, other_fault, clear,
    output rise_cycles,
    input power_en, retrying
  );
  modport seq (
    input act_enable, restart_on, ov_event, on_cmd, other_fault, clear,
    input rise_cycles,
    output power_en, retrying
  );
endinterface : cofp_seq_if

// File: rtl/cofp_seq.sv
// Overvoltage shutdown and restart sequencer.
// Assumes one-cycle OV events and clear pulses from the register side.
`timescale 1ns/1ps
module cofp_seq
  import cofp_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  cofp_seq_if.seq sq
);

  cofp_seq_reg_t s;
  cofp_seq_reg_t next_s;
  logic on_ok;
  logic span_done;
  logic trip;

  // Run permission and timing helpers
  assign on_ok = sq.on_cmd & ~sq.other_fault;
  assign span_done = ({1'b0, s.cnt} + 1'b1) >= {1'b0, sq.rise_cycles};
  assign trip = sq.ov_event & sq.act_enable;

  // Next state
  always_comb begin
    next_s = s;
    case (s.state)
      SEQ_IDLE: begin
        if (on_ok) begin
          next_s.state = SEQ_RAMP;
          next_s.cnt = '0;
        end
      end
      SEQ_RUN, SEQ_RAMP: begin
        if (!on_ok) begin
          next_s.state = SEQ_IDLE;
        end else if (trip) begin
          next_s.cnt = '0;
          next_s.rep = '0;
          if (sq.restart_on) begin
            next_s.state = SEQ_WAIT;
          end else begin
            next_s.state = SEQ_LATCH;
          end
        end else if (s.state == SEQ_RAMP) begin
          next_s.cnt = s.cnt + 1'b1;
          if (span_done) begin
            next_s.state = SEQ_RUN;
          end
        end
      end
      SEQ_LATCH: begin
        if (sq.clear || !on_ok) begin
          next_s.state = SEQ_IDLE;
        end
      end
      SEQ_WAIT: begin
        if (!on_ok) begin
          next_s.state = SEQ_IDLE;
        end else if (span_done) begin
          next_s.cnt = '0;
          next_s.rep = s.rep + 1'b1;
          if (s.rep == RETRY_RISE_COUNT - 3'h1) begin
            next_s.state = SEQ_RAMP;
          end
        end else begin
          next_s.cnt = s.cnt + 1'b1;
        end
      end
      default: begin
        next_s.state = SEQ_IDLE;
      end
    endcase
    next_s.power_en = (next_s.state == SEQ_RUN) ||
                      (next_s.state == SEQ_RAMP);
    next_s.retrying = (next_s.state == SEQ_WAIT);
  end

  // State register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '{state: SEQ_IDLE, cnt: '0, rep: '0, power_en: 1'b0,
             retrying: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign sq.power_en = s.power_en;
  assign sq.retrying = s.retrying;

endmodule : cofp_seq

// File: tb/cofp_host.sv
// PMBus host model driving the command port of the device.
// Assumes the device answers one cycle after each strobe.
`timescale 1ns/1ps
module cofp_host (
  input wire logic clk,
  output logic cmd_valid,
  output logic cmd_write,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_wdata,
  input wire logic rsp_valid,
  input wire logic rsp_nack,
  input wire logic [15:0] rsp_rdata
);
  // Idle bus at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end
  // One command: strobe for one edge, then take the answer
  task automatic xfer(input logic w, input logic [7:0] c,
    input logic [15:0] d, output logic nk, output logic [15:0] r);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_code = c;
    cmd_wdata = d;
    @(negedge clk);
    nk = rsp_valid ? rsp_nack : 1'b1;
    r = rsp_valid ? rsp_rdata : 16'hxxxx;
    cmd_valid = 1'b0;
    cmd_wdata = ~d; // Released data never repeats the last word
  endtask : xfer
endmodule : cofp_host

// File: tb/cofp_properties.sv
// Port-level checks of the trim and OV fault policy block.
// Assumes one clock and no command within four edges of reset.
`timescale 1ns/1ps
module cofp_properties
  import cofp_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic CMD_VALID,
  input wire logic CMD_WRITE,
  input wire logic [7:0] CMD_CODE,
  input wire logic [15:0] CMD_WDATA,
  input wire logic LOOP_SLAVE,
  input wire logic OV_DETECT,
  input wire logic RSP_VALID,
  input wire logic RSP_NACK,
  input wire logic [15:0] RSP_RDATA,
  input wire logic STAT_VOUT_OV,
  input wire logic STAT_CML_IVC,
  input wire logic STAT_CML_IVD,
  input wire logic SMBALERT_OE,
  input wire logic NV_STORE,
  input wire logic RETRY_PENDING,
  input wire logic POWER_EN,
  input wire logic [RISE_W-1:0] RISE_CYCLES
);
  logic rd_q, clr_q, clr_qq, st_q, st_qq, ov_w, bad_w;
  logic [31:0] wait_len;
  logic [7:0] code_q;
  // Delayed command history
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      {rd_q, clr_q, clr_qq, st_q, st_qq} <= 5'h00;
      code_q <= 8'h00;
      wait_len <= 32'h0000_0000;
    end else begin
      wait_len <= RETRY_PENDING ? wait_len + 32'h0000_0001 : 32'h0000_0000;
      rd_q <= CMD_VALID && !CMD_WRITE;
      code_q <= CMD_CODE;
      clr_q <= CMD_VALID && CMD_WRITE && CMD_CODE == CMD_CLEAR_FAULTS;
      clr_qq <= clr_q;
      st_q <= CMD_VALID && CMD_WRITE && CMD_CODE == CMD_STORE_ALL;
      st_qq <= st_q;
    end
  end
  // Decoded policy commands
  assign ov_w = CMD_VALID && CMD_CODE == CMD_OV_ACTION;
  assign bad_w = ov_w && CMD_WRITE && !LOOP_SLAVE &&
    CMD_WDATA[5:3] != 3'h0 && CMD_WDATA[5:3] != 3'h7;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  a_trim_fixed_bits: assert property (
    RSP_VALID && !RSP_NACK && rd_q && code_q == CMD_TRIM |->
    RSP_RDATA[15:11] == 5'h1c && RSP_RDATA[10:6] inside {5'h00, 5'h1f})
    else $error("trim read has wrong fixed bits");
  a_delay_mirror: assert property (
    RSP_VALID && !RSP_NACK && rd_q && code_q == CMD_OV_ACTION |->
    RSP_RDATA[15:6] == 10'h000 && RSP_RDATA[5:0] inside {6'h00, 6'h3f}
    || RSP_RDATA[15:6] == 10'h002 && RSP_RDATA[5:0] inside {6'h00, 6'h3f})
    else $error("OV action read is not a mirrored image");
  a_ov_flagged: assert property (
    $rose(OV_DETECT) |=> STAT_VOUT_OV)
    else $error("OV event did not set the flag");
  a_flags_sticky: assert property (
    $fell(STAT_VOUT_OV) || $fell(STAT_CML_IVD) |-> clr_qq)
    else $error("flag dropped without clear");
  a_bad_mode: assert property (
    bad_w |=> RSP_VALID && !RSP_NACK && STAT_CML_IVD && SMBALERT_OE)
    else $error("bad restart mode not flagged");
  a_slave_refused: assert property (
    ov_w && LOOP_SLAVE |=> RSP_NACK && STAT_CML_IVC && SMBALERT_OE)
    else $error("loop slave access not refused");
  a_retry_wait: assert property (
    $fell(RETRY_PENDING) && POWER_EN |->
    wait_len == 32'(RISE_CYCLES) * 32'h0000_0007)
    else $error("retry wait is not seven rise times");
  a_store_pulse: assert property (
    NV_STORE |-> (st_q || st_qq) ##1 !NV_STORE)
    else $error("store pulse without store command");
  c_retry: cover property ($rose(RETRY_PENDING));
  c_bad: cover property (bad_w);
  c_masked: cover property ($rose(STAT_VOUT_OV) && !SMBALERT_OE);
endmodule : cofp_properties

bind cofp_top cofp_properties chk_u (.SYS_CLK, .RESET_N, .CMD_VALID,
  .CMD_WRITE, .CMD_CODE, .CMD_WDATA, .LOOP_SLAVE, .OV_DETECT, .RSP_VALID,
  .RSP_NACK, .RSP_RDATA, .STAT_VOUT_OV, .STAT_CML_IVC, .STAT_CML_IVD,
  .SMBALERT_OE, .NV_STORE, .RETRY_PENDING, .POWER_EN, .RISE_CYCLES);

// File: tb/tb.sv
// Self-checking bench for the trim and OV fault policy block.
// Assumes the host model owns the command port.
`timescale 1ns/1ps
module tb;
  import cofp_pkg::*;
  localparam int RISE = 4;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic loop_slave = 1'b0, ov = 1'b0, mask = 1'b0, out_on = 1'b1;
  logic oth = 1'b0;
  logic cv, cw, rv, rn, sov, invalid_command_fault, ivd, oe, nvs, pen, rtp, nk;
  logic [7:0] cc;
  logic [15:0] cd, rd, iadj, fadj, wadj, got;
  logic [15:0] iraw = 16'h0100;
  logic [6:0] nvt;
  logic [1:0] nvo;
  int failures = 0, tests_run = 0, cyc = 0;

  cofp_top dut_u (
    .SYS_CLK(sys_clk), .RESET_N(reset_n), .CMD_VALID(cv), .CMD_WRITE(cw),
    .CMD_CODE(cc), .CMD_WDATA(cd), .LOOP_SLAVE(loop_slave),
    .OV_DETECT(ov), .ALERT_MASK_OV(mask), .OUTPUT_ON(out_on),
    .OTHER_FAULT(oth), .RISE_CYCLES(24'(RISE)), .IOUT_RAW(iraw),
    .OC_FAULT_RAW(iraw), .OC_WARN_RAW(iraw), .RSP_VALID(rv),
    .RSP_NACK(rn), .RSP_RDATA(rd), .IOUT_ADJ(iadj), .OC_FAULT_ADJ(fadj),
    .OC_WARN_ADJ(wadj), .STAT_VOUT_OV(sov), .STAT_CML_IVC(invalid_command_fault),
    .STAT_CML_IVD(ivd), .SMBALERT_O(), .SMBALERT_OE(oe), .NV_STORE(nvs),
    .NV_TRIM_BITS(nvt), .NV_OV_BITS(nvo), .POWER_EN(pen),
    .RETRY_PENDING(rtp));
  cofp_host host_u (.clk(sys_clk), .cmd_valid(cv), .cmd_write(cw),
    .cmd_code(cc), .cmd_wdata(cd), .rsp_valid(rv), .rsp_nack(rn),
    .rsp_rdata(rd));

  // Clock and hang guard
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures++;
      summarize();
    end
  end

  task automatic summarize;
    $display("Checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    host_u.xfer(1'b1, c, d, nk, got);
  endtask : wr
  task automatic rdc(input logic [7:0] c, input logic [15:0] e);
    host_u.xfer(1'b0, c, 16'h0000, nk, got);
    chk(got, e);
  endtask : rdc
  task automatic clr;
    wr(CMD_CLEAR_FAULTS, 16'h0000);
    @(negedge sys_clk);
  endtask : clr
  task automatic do_reset(input logic s);
    @(negedge sys_clk);
    reset_n = 1'b0;
    loop_slave = s;
    repeat (8) @(negedge sys_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge sys_clk);
  endtask : do_reset

  // Trim writes with out-of-span bits, offsets and store
  task automatic t_trim;
    logic [15:0] wv [3] = '{16'h07ff, 16'hfbc1, 16'h0400};
    logic [15:0] ev [3] = '{16'he7ff, 16'he001, 16'he7c0};
    rdc(CMD_TRIM, 16'he000);
    rdc(CMD_OV_ACTION, 16'h00bf);
    chk(iadj, iraw);
    foreach (wv[i]) begin
      wr(CMD_TRIM, wv[i]);
      rdc(CMD_TRIM, ev[i]);
    end
    chk(iadj, 16'h00c0);
    chk(fadj, 16'h0140);
    chk(wadj, 16'h0140);
    wr(CMD_STORE_ALL, 16'h0000);
    for (int i = 0; i < 4 && nvs !== 1'b1; i++) @(negedge sys_clk);
    chk(16'({nvs, nvt, nvo}), 16'h0303);
    wr(CMD_TRIM, 16'h0000);
  endtask : t_trim

  // Default policy: shut down, wait seven rise times, restart
  task automatic t_retry;
    int n = 0;
    for (int i = 0; i < 40 && pen !== 1'b1; i++) @(negedge sys_clk);
    ov = 1'b1;
    for (int i = 0; i < 5 && rtp !== 1'b1; i++) @(negedge sys_clk);
    chk(16'({sov, oe, pen}), 16'h0006);
    while (rtp === 1'b1 && n < 100) begin
      n++;
      @(negedge sys_clk);
    end
    chk(16'(n), 16'(7 * RISE));
    for (int i = 0; i < 10 && pen !== 1'b1; i++) @(negedge sys_clk);
    chk(16'(pen), 16'h0001);
    ov = 1'b0;
    clr();
    // Another fault during the retry wait ends the retries
    ov = 1'b1;
    repeat (3) @(negedge sys_clk);
    oth = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk(16'({rtp, pen}), 16'h0000);
    oth = 1'b0;
    ov = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk(16'(pen), 16'h0001);
    clr();
  endtask : t_retry

  // Policy register codes, a refused mode and sticky flags
  task automatic t_ovreg;
    wr(CMD_OV_ACTION, 16'h0038);
    rdc(CMD_OV_ACTION, 16'h003f);
    wr(CMD_OV_ACTION, 16'h0088);
    chk(16'({ivd, oe, nk}), 16'h0006);
    rdc(CMD_STATUS_CML, 16'h0040);
    rdc(CMD_STATUS_BYTE, 16'h0002);
    rdc(CMD_OV_ACTION, 16'h003f);
    wr(CMD_OV_ACTION, 16'h0000);
    rdc(CMD_OV_ACTION, 16'h0000);
    repeat (5) @(negedge sys_clk);
    chk(16'(ivd), 16'h0001);
    clr();
    chk(16'({ivd, oe}), 16'h0000);
  endtask : t_ovreg

  // Ignore mode keeps running, alert obeys the mask
  task automatic t_ignore;
    mask = 1'b1;
    ov = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk(16'({sov, oe, pen}), 16'h0005);
    rdc(CMD_STATUS_BYTE, 16'h0020);
    rdc(CMD_STATUS_WORD, 16'h8020);
    rdc(CMD_STATUS_VOUT, 16'h0080);
    mask = 1'b0;
    ov = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk(16'({oe, pen}), 16'h0003);
    clr();
  endtask : t_ignore

  // Latch-off mode stays off until faults are cleared
  task automatic t_latch;
    wr(CMD_OV_ACTION, 16'h0080);
    ov = 1'b1;
    repeat (40) @(negedge sys_clk);
    chk(16'({sov, pen, rtp}), 16'h0004);
    ov = 1'b0;
    clr();
    for (int i = 0; i < 10 && pen !== 1'b1; i++) @(negedge sys_clk);
    chk(16'(pen), 16'h0001);
  endtask : t_latch

  // Loop slave refuses the policy command
  task automatic t_slave;
    do_reset(1'b1);
    host_u.xfer(1'b0, CMD_OV_ACTION, 16'h0000, nk, got);
    chk(16'({nk, invalid_command_fault, oe}), 16'h0007);
    host_u.xfer(1'b1, CMD_OV_ACTION, 16'h0000, nk, got);
    chk(16'(nk), 16'h0001);
    rdc(CMD_TRIM, 16'he000);
    rdc(CMD_STATUS_CML, 16'h0080);
    do_reset(1'b0);
  endtask : t_slave

  // Main sequence
  initial begin
    do_reset(1'b0);
    t_trim();
    t_retry();
    t_ovreg();
    t_ignore();
    t_latch();
    t_slave();
    summarize();
  end
endmodule : tb
